// *** core/ltc_pkg.sv ***
// constants, field layout and register map of the lifetime timer
// assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock
//
// Contract
// (RULE1) free-running restarts at maximum or minimum value
// (RULE2) periodic restarts from the reload value
// (RULE3) interrupt on reaching zero or full scale
// (RULE4) any clear-strobe write clears pending interrupt
// (RULE5) count readable any time, even while running
// (RULE6) enable bit 7 runs counter, cleared at reset
// (RULE7) bit 4 selects 16-bit or 48-bit width
// (RULE8) 48-bit width counts up only from zero
// (RULE9) bit 8 sets 16-bit direction, default down
// (RULE10) bit 6 selects periodic or free-running mode
// (RULE11) 48-bit count split in low and high
// (RULE12) reload, capture, clear only in 16-bit width
// (RULE13) reload on overflow and on clear write
// (RULE14) first source assertion copies count, counter runs
// (RULE15) bit 17 enables event capture
// (RULE16) bits 16:12 name the capture trigger source
// (RULE17) bits 10:9 select the counter clock
// (RULE18) bits 3:0 select prescaler 1/16/256/32768
// (RULE19) other prescaler codes divide by one
package ltc_pkg;

    // register byte addresses
    localparam logic [31:0] LTC_RELOAD_ADDR = 32'hFFFF0300;
    localparam logic [31:0] LTC_CNT_LO_ADDR = 32'hFFFF0304;
    localparam logic [31:0] LTC_CNT_HI_ADDR = 32'hFFFF0308;
    localparam logic [31:0] LTC_CTRL_ADDR = 32'hFFFF030C;
    localparam logic [31:0] LTC_ICLR_ADDR = 32'hFFFF0310;
    localparam logic [31:0] LTC_CAP_ADDR = 32'hFFFF0314;

    // control register layout and values after reset
    localparam int LTC_CTRL_W = 18;
    localparam logic [17:0] LTC_CTRL_WMASK = 18'h3F7DF;
    localparam logic [17:0] LTC_CTRL_RST = 18'h00000;
    localparam logic [15:0] LTC_RELOAD_RST = 16'h0000;
    localparam logic [15:0] LTC_CAP_RST = 16'h0000;
    localparam logic [47:0] LTC_CNT_RST = 48'h000000000000;

    // clock select codes
    localparam logic [1:0] LTC_CLK_OSC = 2'h0;
    localparam logic [1:0] LTC_CLK_UNDIV = 2'h1;
    localparam logic [1:0] LTC_CLK_XTAL = 2'h2;
    localparam logic [1:0] LTC_CLK_CORE = 2'h3;

    // prescaler codes and the matching terminal counts
    localparam logic [3:0] LTC_PSC_DIV16 = 4'h4;
    localparam logic [3:0] LTC_PSC_DIV256 = 4'h8;
    localparam logic [3:0] LTC_PSC_DIV32K = 4'hF;
    localparam logic [14:0] LTC_PSC_T1 = 15'h0000;
    localparam logic [14:0] LTC_PSC_T16 = 15'h000F;
    localparam logic [14:0] LTC_PSC_T256 = 15'h00FF;
    localparam logic [14:0] LTC_PSC_T32K = 15'h7FFF;

    // capture source codes
    localparam int LTC_NSRC = 18;
    localparam logic [4:0] LTC_SRC_MAX = 5'h11;

    // axi responses
    localparam logic [1:0] LTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] LTC_RESP_SLVERR = 2'h2;

    // control register fields, msb first
    typedef struct packed {
        logic cap_en;
        logic [4:0] cap_src;
        logic rsvd11;
        logic [1:0] clk_sel;
        logic count_up;
        logic enable;
        logic periodic;
        logic rsvd5;
        logic wide;
        logic [3:0] prescale;
    } ltc_ctrl_t;

endpackage

// *** core/ltc_timer.sv ***
// lifetime timer: 48-bit up or 16-bit up/down counter with capture
// assumes an AXI4-Lite master on aclk and asynchronous clock pins
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module ltc_timer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // counter clock pins, asynchronous
    input wire logic osc32k_in,
    input wire logic undivided_clock_in,
    input wire logic xtal32k_in,
    // other interrupt sources, codes 1 to 17, on aclk
    input wire logic [17:1] irq_src_in,
    // timer interrupt
    output logic timer_irq
);

    ////////////////////////////////////////////////////////////////
    // state

    logic [17:0] ctrl_ff;
    logic [15:0] reload_ff;
    logic [15:0] cap_ff;
    logic [47:0] cnt_ff;
    logic [14:0] psc_ff;
    logic irq_ff;
    logic src_prev_ff;

    logic aw_held_ff;
    logic w_held_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic [2:0] sync3_ff;

    ltc_pkg::ltc_ctrl_t ctrl;
    assign ctrl = ltc_pkg::ltc_ctrl_t'(ctrl_ff);

    ////////////////////////////////////////////////////////////////
    // clock pins: two flops, then a third for edge detect

    wire [2:0] pin_raw = {xtal32k_in, undivided_clock_in, osc32k_in};
    wire [2:0] pin_rise;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                    sync3_ff[gi] <= 1'b0;
                end else begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    sync3_ff[gi] <= sync2_ff[gi];
                end
            end
            // edge seen only past the second flop
            assign pin_rise[gi] = sync2_ff[gi] & ~sync3_ff[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // source clock select and prescaler

    // pins slower than aclk/4 give one tick per rising edge
    // a faster pin aliases and loses edges; the core clock never does
    wire src_tick =
        (ctrl.clk_sel == ltc_pkg::LTC_CLK_OSC) ? pin_rise[0] : // RULE17
        (ctrl.clk_sel == ltc_pkg::LTC_CLK_UNDIV) ? pin_rise[1] :
        (ctrl.clk_sel == ltc_pkg::LTC_CLK_XTAL) ? pin_rise[2] :
        1'b1;

    // unlisted codes fall back to divide-by-one
    wire [14:0] psc_term =
        (ctrl.prescale == ltc_pkg::LTC_PSC_DIV16) ? ltc_pkg::LTC_PSC_T16 : // RULE18
        (ctrl.prescale == ltc_pkg::LTC_PSC_DIV256) ? ltc_pkg::LTC_PSC_T256 :
        (ctrl.prescale == ltc_pkg::LTC_PSC_DIV32K) ? ltc_pkg::LTC_PSC_T32K :
        ltc_pkg::LTC_PSC_T1; // RULE19

    wire psc_hit = src_tick & (psc_ff == psc_term);
    wire cnt_tick = ctrl.enable & psc_hit; // RULE6

    ////////////////////////////////////////////////////////////////
    // axi write channel

    wire aw_hs = s_axi_awvalid & awready_ff;
    wire w_hs = s_axi_wvalid & wready_ff;
    wire [31:0] wr_addr = aw_hs ? s_axi_awaddr : awaddr_ff;
    wire [31:0] wr_data = w_hs ? s_axi_wdata : wdata_ff;
    wire [3:0] wr_strb = w_hs ? s_axi_wstrb : wstrb_ff;
    wire aw_have = aw_hs | aw_held_ff;
    wire w_have = w_hs | w_held_ff;
    wire wr_go = aw_have & w_have & ~bvalid_ff;

    // decode of the write address
    wire wr_reload = wr_go & (wr_addr == ltc_pkg::LTC_RELOAD_ADDR);
    wire wr_ctrl = wr_go & (wr_addr == ltc_pkg::LTC_CTRL_ADDR);
    wire wr_iclr = wr_go & (wr_addr == ltc_pkg::LTC_ICLR_ADDR);
    wire wr_ro = wr_go & ((wr_addr == ltc_pkg::LTC_CNT_LO_ADDR) |
        (wr_addr == ltc_pkg::LTC_CNT_HI_ADDR) |
        (wr_addr == ltc_pkg::LTC_CAP_ADDR));
    wire wr_ok = wr_reload | wr_ctrl | wr_iclr | wr_ro;

    // byte-lane merge of a write into the old values, one lane per pass
    wire [31:0] ctrl_old = {14'h0000, ctrl_ff};
    wire [31:0] reload_old = {16'h0000, reload_ff};
    wire [31:0] ctrl_merged;
    wire [31:0] reload_merged;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_lane
            // a lane whose strobe is low keeps its old byte
            assign ctrl_merged[gb*8 +: 8] =
                wr_strb[gb] ? wr_data[gb*8 +: 8] : ctrl_old[gb*8 +: 8];
            assign reload_merged[gb*8 +: 8] =
                wr_strb[gb] ? wr_data[gb*8 +: 8] : reload_old[gb*8 +: 8];
        end
    endgenerate

    // reserved control bits never store
    wire [17:0] nxt_ctrl_w = (ctrl_merged[17:0] & ltc_pkg::LTC_CTRL_WMASK);
    // field view of the value a control write would store
    ltc_pkg::ltc_ctrl_t nxt_ctrl_view;
    assign nxt_ctrl_view = ltc_pkg::ltc_ctrl_t'(nxt_ctrl_w);
    // clear acts in 16-bit width only, any data value
    wire iclr_hit = wr_iclr & ~ctrl.wide; // RULE4 RULE12

    ////////////////////////////////////////////////////////////////
    // counter next value

    wire up = ctrl.wide | ctrl.count_up; // RULE8 RULE9
    wire [15:0] lo = cnt_ff[15:0];
    wire [15:0] term16 = up ? 16'hFFFF : 16'h0000;
    wire [15:0] free16 = up ? 16'h0000 : 16'hFFFF;
    wire [15:0] start16 = ctrl.periodic ? reload_ff : free16; // RULE1 RULE2 RULE10
    wire [15:0] step16 = up ? (lo + 16'h0001) : (lo - 16'h0001);
    wire [15:0] lo_adv = (lo == term16) ? start16 : step16;
    wire [47:0] cnt_inc = cnt_ff + 48'h000000000001;

    logic [47:0] nxt_cnt;
    logic nxt_set;

    // control write setting wide restarts; clear write reloads; tick steps
    // a clear landing on a tick wins: the reload replaces that step,
    // so no interrupt is raised from a count that never happened
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_set = 1'b0;
        if (wr_ctrl && nxt_ctrl_view.wide) begin
            nxt_cnt = ltc_pkg::LTC_CNT_RST; // RULE8
        end else if (iclr_hit) begin
            nxt_cnt = {32'h00000000, reload_ff}; // RULE13
        end else if (cnt_tick && ctrl.wide) begin
            nxt_cnt = cnt_inc; // RULE7 RULE11
        end else if (cnt_tick) begin
            nxt_cnt = {32'h00000000, lo_adv}; // RULE13
            nxt_set = (lo_adv == term16); // RULE3
        end
    end

    // a clear in the same cycle wins, since nxt_set is then low
    wire nxt_irq = nxt_set | (irq_ff & ~iclr_hit); // RULE4

    ////////////////////////////////////////////////////////////////
    // capture trigger

    wire [17:0] src_vec = {irq_src_in, irq_ff};
    wire src_valid = (ctrl.cap_src <= ltc_pkg::LTC_SRC_MAX);
    wire src_lvl = src_valid & src_vec[ctrl.cap_src]; // RULE16
    // previous level is tracked under every code, so a code change onto
    // a source that is already high counts as one rising edge
    wire src_rise = src_lvl & ~src_prev_ff;
    // capture does not disturb the counter path
    wire cap_go = ctrl.cap_en & ~ctrl.wide & src_rise; // RULE14 RULE15

    ////////////////////////////////////////////////////////////////
    // timer registers

    // software-written control and reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= ltc_pkg::LTC_CTRL_RST; // RULE6
            reload_ff <= ltc_pkg::LTC_RELOAD_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= nxt_ctrl_w;
            end
            if (wr_reload) begin
                reload_ff <= reload_merged[15:0];
            end
        end
    end

    // capture keeps its value until the next trigger
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_ff <= ltc_pkg::LTC_CAP_RST;
            src_prev_ff <= 1'b0;
        end else begin
            if (cap_go) begin
                cap_ff <= lo; // RULE14
            end
            src_prev_ff <= src_lvl;
        end
    end

    // count and pending interrupt move on the same edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= ltc_pkg::LTC_CNT_RST;
            irq_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            irq_ff <= nxt_irq;
        end
    end

    // prescaler restarts on a control write or while stopped
    // so the first count after enable always takes a full period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psc_ff <= 15'h0000;
        end else if (wr_ctrl || !ctrl.enable || psc_hit) begin
            psc_ff <= 15'h0000;
        end else if (src_tick) begin
            psc_ff <= psc_ff + 15'h0001; // RULE18
        end
    end

    ////////////////////////////////////////////////////////////////
    // axi write handshake

    // address and data held until both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff <= 32'h00000000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_hs) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
        end
    end

    // one write in flight: each ready drops once its channel is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= ltc_pkg::LTC_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                awready_ff <= 1'b0;
            end
            if (w_hs) begin
                wready_ff <= 1'b0;
            end
            if (wr_go) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? ltc_pkg::LTC_RESP_OKAY : ltc_pkg::LTC_RESP_SLVERR;
            end else begin
                aw_held_ff <= aw_have;
                w_held_ff <= w_have;
            end
            // both channels reopen once the response is taken
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // axi read channel

    wire ar_hs = s_axi_arvalid & arready_ff;

    // read mux; the count is sampled live, no snapshot
    // software reading high then low may see a carry in between
    wire rd_lo = (s_axi_araddr == ltc_pkg::LTC_CNT_LO_ADDR);
    wire rd_hi = (s_axi_araddr == ltc_pkg::LTC_CNT_HI_ADDR);
    wire rd_ctrl = (s_axi_araddr == ltc_pkg::LTC_CTRL_ADDR);
    wire rd_cap = (s_axi_araddr == ltc_pkg::LTC_CAP_ADDR);
    wire rd_reload = (s_axi_araddr == ltc_pkg::LTC_RELOAD_ADDR);
    wire rd_iclr = (s_axi_araddr == ltc_pkg::LTC_ICLR_ADDR);
    wire rd_ok = rd_lo | rd_hi | rd_ctrl | rd_cap | rd_reload | rd_iclr;
    wire [31:0] rd_mux =
        rd_lo ? {16'h0000, cnt_ff[15:0]} : // RULE5 RULE11
        rd_hi ? cnt_ff[47:16] : // RULE11
        rd_ctrl ? {14'h0000, ctrl_ff} :
        rd_cap ? {16'h0000, cap_ff} :
        rd_reload ? {16'h0000, reload_ff} :
        32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= ltc_pkg::LTC_RESP_OKAY;
        end else if (ar_hs) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_ok ? ltc_pkg::LTC_RESP_OKAY : ltc_pkg::LTC_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs straight from flops

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign timer_irq = irq_ff; // RULE3

endmodule // ltc_timer

`default_nettype wire

// *** tb/ltc_timer_assertions.sv ***
// assertions on the bus and interrupt ports of the lifetime timer
// assumes a bind into ltc_timer, single clock domain
`timescale 1ns/1ps
`default_nettype none

module ltc_timer_assertions (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // interrupt
    input wire logic timer_irq
);
////////////////////////////////////////
default clocking @(posedge aclk);
endclocking
default disable iff (!aresetn);

// handshakes and decode; the map is six aligned words from offset 300
wire logic aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
wire logic ar_go = s_axi_arvalid && s_axi_arready;
wire logic aw_map = (s_axi_awaddr[31:5] == 27'h7FFF818) && (s_axi_awaddr[4:0] <= 5'h14)
    && (s_axi_awaddr[1:0] == 2'h0);
wire logic ar_map = (s_axi_araddr[31:5] == 27'h7FFF818) && (s_axi_araddr[4:0] <= 5'h14)
    && (s_axi_araddr[1:0] == 2'h0);
////////////////////////////////////////
// bus answers and holding
chk_wr_answer: assert property (aw_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered in the next cycle");
chk_wr_error: assert property (aw_go && !aw_map |=> s_axi_bresp == ltc_pkg::LTC_RESP_SLVERR)
    else $error("unmapped write not refused");
chk_wr_okay: assert property (aw_go && aw_map |=> s_axi_bresp == ltc_pkg::LTC_RESP_OKAY)
    else $error("mapped write refused");
chk_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && !s_axi_bvalid)
    else $error("write side not free after response");
chk_rd_answer: assert property (ar_go |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered in the next cycle");
chk_rd_error: assert property (ar_go && !ar_map |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved while stalled");
// a pending interrupt only drops at the response edge of a write
chk_irq_clear: assert property ($fell(timer_irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a write");
cover property ($rose(timer_irq));
cover property (aw_go && !aw_map);
cover property (s_axi_rvalid && !s_axi_rready);

endmodule // ltc_timer_assertions

bind ltc_timer ltc_timer_assertions u_chk (.*);

`default_nettype wire

// *** tb/test_lifetime_timer_with_capture.sv ***
// self-checking bench for the lifetime timer over its register bus
// assumes ltc_timer and the checker bound to it
`timescale 1ns/1ps
`default_nettype none

module test_lifetime_timer_with_capture;

logic aclk = 1'h0;
logic aresetn = 1'h0;
logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rv;
logic [3:0] s_axi_wstrb = 4'hF;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_irq;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [17:1] irq_src_in = 17'h0;
logic [2:0] pins = 3'h0;
logic [31:0] pc [4] = '{32'h0, 32'h3, 32'h8, 32'hF};
int n_fail = 0;
int comparisons = 0;
// clock pins idle low between pulses
wire logic osc32k_in = pins[0];
wire logic undivided_clock_in = pins[1];
wire logic xtal32k_in = pins[2];

ltc_timer i_dut (.*);
////////////////////////////////////////
// 200 MHz clock
initial begin
    forever #2.5 aclk = ~aclk;
end

task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
        n_fail++;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask

task automatic finish_test();
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask

// write: address and data together, bready held until the response
task automatic wr(input logic [31:0] a, input logic [31:0] d,
    input logic [1:0] er = ltc_pkg::LTC_RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check({46'h0, s_axi_bresp}, {46'h0, er});
endtask

// read: rready raised late so the answer has to stand one cycle
task automatic rd(input logic [31:0] a, input logic [47:0] e, input logic ck = 1'h1,
    input logic [1:0] er = ltc_pkg::LTC_RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
    rv = s_axi_rdata;
    check({46'h0, s_axi_rresp}, {46'h0, er});
    if (ck) check({16'h0, rv}, e);
endtask

// stopped timer: set reload, then clear strobe loads the count
task automatic load(input logic [15:0] v);
    wr(ltc_pkg::LTC_RELOAD_ADDR, {16'h0, v});
    wr(ltc_pkg::LTC_ICLR_ADDR, 32'h0);
endtask

// core clock /16 runs about 24 cycles: exactly one count tick
task automatic one_tick(input logic [31:0] c);
    wr(ltc_pkg::LTC_CTRL_ADDR, c | 32'h680);
    repeat (20) @(posedge aclk);
    wr(ltc_pkg::LTC_CTRL_ADDR, c | 32'h600);
endtask

task automatic pulse(input int b);
    @(posedge aclk) irq_src_in[b] <= 1'h1;
    @(posedge aclk) irq_src_in[b] <= 1'h0;
endtask
////////////////////////////////////////
// watchdog, far beyond the thousand or so cycles of the tests
initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    finish_test();
end

// main sequence
initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ltc_pkg::LTC_CTRL_ADDR, 48'h0);
    rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'h0);
    rd(ltc_pkg::LTC_CNT_HI_ADDR, 48'h0);
    rd(ltc_pkg::LTC_CAP_ADDR, 48'h0);
    rd(32'hFFFF0318, 48'h0, 1'h1, ltc_pkg::LTC_RESP_SLVERR);
    wr(32'hFFFF0318, 32'h0, ltc_pkg::LTC_RESP_SLVERR);
    wr(ltc_pkg::LTC_CTRL_ADDR, 32'hFFFFFFFF);
    rd(ltc_pkg::LTC_CTRL_ADDR, 48'h3F7DF);
    wr(ltc_pkg::LTC_CTRL_ADDR, 32'h0);
    // down, free-running: 1 -> 0 with interrupt -> FFFF
    load(16'h1);
    one_tick(32'h4);
    rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'h0);
    check({47'h0, timer_irq}, 48'h1);
    one_tick(32'h4);
    rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'hFFFF);
    check({47'h0, timer_irq}, 48'h1);
    load(16'h7);
    check({47'h0, timer_irq}, 48'h0);
    rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'h7);
    // up, free-running: FFFE -> FFFF with interrupt -> 0
    load(16'hFFFE);
    one_tick(32'h104);
    rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'hFFFF);
    check({47'h0, timer_irq}, 48'h1);
    one_tick(32'h104);
    rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'h0);
    // periodic: after zero the count restarts from reload
    load(16'h1);
    one_tick(32'h44);
    one_tick(32'h44);
    rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'h1);
    // prescaler codes: /1 and undefined move, /256 and /32768 hold
    for (int i = 0; i < 4; i++) begin
        load(16'h100);
        one_tick(pc[i]);
        rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'h0, 1'h0);
        check({47'h0, i < 2 ? (rv > 32'hE1 && rv < 32'hED) : rv == 32'h100}, 48'h1);
    end
    // each clock pin pulsed a different number of times
    for (int s = 0; s < 3; s++) begin
        load(16'h100);
        wr(ltc_pkg::LTC_CTRL_ADDR, {21'h0, s[1:0], 9'h080});
        for (int p = 0; p < 3; p++) begin
            repeat (p + 1) begin
                @(posedge aclk) pins[p] <= 1'h1;
                repeat (4) @(posedge aclk);
                pins[p] <= 1'h0;
                repeat (4) @(posedge aclk);
            end
        end
        wr(ltc_pkg::LTC_CTRL_ADDR, 32'h0);
        rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'(32'hFF - s));
    end
    // 48-bit: up from zero, clear strobe ignored, no interrupt
    load(16'h5);
    wr(ltc_pkg::LTC_CTRL_ADDR, 32'h690);
    repeat (40) @(posedge aclk);
    wr(ltc_pkg::LTC_ICLR_ADDR, 32'h0);
    rd(ltc_pkg::LTC_CNT_LO_ADDR, 48'h0, 1'h0);
    check({47'h0, rv > 32'h28 && rv < 32'h40}, 48'h1);
    rd(ltc_pkg::LTC_CNT_HI_ADDR, 48'h0);
    check({47'h0, timer_irq}, 48'h0);
    wr(ltc_pkg::LTC_CTRL_ADDR, 32'h0);
    // capture from sources 1..17; a neighbour source must not capture
    for (int k = 1; k < 18; k++) begin
        load(16'h20 + k[15:0]);
        wr(ltc_pkg::LTC_CTRL_ADDR, {14'h0, 1'h1, k[4:0], 12'h0});
        pulse(k);
        load(16'h0);
        pulse(k % 17 + 1);
        rd(ltc_pkg::LTC_CAP_ADDR, 48'h20 + 48'(k));
    end
    wr(ltc_pkg::LTC_CTRL_ADDR, 32'h11000);
    pulse(17);
    rd(ltc_pkg::LTC_CAP_ADDR, 48'h31);
    // source 0 is the timer's own interrupt, rising as the count hits zero
    load(16'h1);
    one_tick(32'h20004);
    rd(ltc_pkg::LTC_CAP_ADDR, 48'h0);
    finish_test();
end

endmodule // test_lifetime_timer_with_capture

`default_nettype wire
